// ### rtl/clm_pkg.sv
// Package for the lock supervision register bank: offsets, fields, reset values, timing
package clm_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] IDX_FREQ_ERR_HI   = 8'h3b;
  localparam logic [7:0] IDX_FREQ_ERR_LO   = 8'h3c;
  localparam logic [7:0] IDX_LOCK_SUP_CTRL = 8'h34;
  localparam logic [7:0] IDX_TOL_SCALE     = 8'h35;
  localparam logic [7:0] IDX_PPM_DELTA     = 8'h64;
  localparam logic [7:0] IDX_EYE_THRESH    = 8'h70;
  // Field positions in lock_supervision_ctrl
  localparam int         BIT_FREQ_RDY      = 7;
  localparam int         BIT_PD_INHIBIT    = 6;
  localparam int         BIT_RECHK_HI      = 5;
  localparam int         BIT_RECHK_LO      = 4;
  // Field positions in lock_tolerance_scale
  localparam int         BIT_SCALE_HI      = 7;
  localparam int         BIT_SCALE_LO      = 6;
  // Reset values
  localparam logic [1:0] RECHK_RESET       = 2'h3;
  localparam logic [7:0] PPM_RESET         = 8'h00;
  localparam logic [7:0] EYE_RESET         = 8'h00;
  localparam logic [1:0] SCALE_RESET       = 2'h0;
  // Idle power-down delay
  localparam int         PD_DELAY_MS       = 100;
  localparam int         CLK_MHZ           = 200;
  localparam int         PD_DELAY_CYCLES   = PD_DELAY_MS * CLK_MHZ * 1000;
  localparam int         PD_CNT_W          = 25;
  // Scaled tolerance width
  localparam int         TOL_W             = 11;

  // Lock supervision state
  typedef enum logic [1:0] {
    CLM_ACQUIRE,
    CLM_LOCKED,
    CLM_RECHECK
  } clm_lock_state_t;

  // Software-owned control fields
  typedef struct packed {
    logic       pd_inhibit;
    logic [1:0] recheck_n;
    logic [1:0] tol_scale;
    logic [7:0] ppm_delta;
    logic [7:0] eye_limits;
  } clm_ctrl_t;

  // Captured frequency-error count
  typedef struct packed {
    logic        ready;
    logic [15:0] count;
  } clm_freq_t;
endpackage

// ### rtl/clm_lock_monitor.sv
// Lock supervision register bank with AHB-Lite slave, re-check FSM and idle power-down
// What this block does
// - Set ready flag when a frequency-error count is captured into the two count registers.
// - Power down all blocks but signal detect on no input, unless inhibited.
// - Keep checking lock criteria continuously after lock is achieved.
// - On failed criteria, re-check N times (max three) before declaring loss of lock.
// - Lock regained during re-checks clears the re-check counter and keeps lock.
// - Two-bit scale multiplies the ppm delta tolerance; code 00 means times one.
// - By default the idle power-down takes effect 100 ms after signal detect falls.
`timescale 1ns/100ps
module clm_lock_monitor #(
  parameter int PD_CYCLES = clm_pkg::PD_DELAY_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic                     sig_detect,
  input  wire logic                     lock_check,
  input  wire logic                     lock_ok,
  input  wire logic                     freq_err_valid,
  input  wire logic [15:0]              freq_err_count,
  output logic                          cdr_locked,
  output logic                          blocks_powered_down,
  output logic [clm_pkg::TOL_W-1:0]     lock_tolerance
);

  clm_pkg::clm_ctrl_t       ctrl_q;
  clm_pkg::clm_freq_t       freq_q;
  clm_pkg::clm_lock_state_t state_q;
  logic [1:0]               rechk_cnt_q;
  logic [clm_pkg::PD_CNT_W-1:0] idle_cnt_q;
  logic                     wr_pend_q;
  logic [7:0]               wr_idx_q;
  logic                     rdy_clr;
  logic [31:0]              rd_word;
  logic                     addr_take;

  // Register index from a byte address
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[9:2];
  endfunction

  assign addr_take = hsel && htrans[1] && hready;

  // Read decode; unmapped indices read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (idx_of(haddr))
      clm_pkg::IDX_LOCK_SUP_CTRL:
      begin
        rd_word[clm_pkg::BIT_FREQ_RDY]   = freq_q.ready;
        rd_word[clm_pkg::BIT_PD_INHIBIT] = ctrl_q.pd_inhibit;
        rd_word[clm_pkg::BIT_RECHK_HI]   = ctrl_q.recheck_n[1];
        rd_word[clm_pkg::BIT_RECHK_LO]   = ctrl_q.recheck_n[0];
      end
      clm_pkg::IDX_TOL_SCALE:
      begin
        rd_word[clm_pkg::BIT_SCALE_HI] = ctrl_q.tol_scale[1];
        rd_word[clm_pkg::BIT_SCALE_LO] = ctrl_q.tol_scale[0];
      end
      clm_pkg::IDX_FREQ_ERR_HI: rd_word[7:0] = freq_q.count[15:8];
      clm_pkg::IDX_FREQ_ERR_LO: rd_word[7:0] = freq_q.count[7:0];
      clm_pkg::IDX_PPM_DELTA:   rd_word[7:0] = ctrl_q.ppm_delta;
      clm_pkg::IDX_EYE_THRESH:  rd_word[7:0] = ctrl_q.eye_limits;
      default:                  rd_word = 32'h0000_0000;
    endcase
  end

  // Bus handshake: reads answer at once, writes add one wait state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end
    else
    begin
      wr_pend_q <= 1'b0;
      hreadyout <= 1'b1;
      if (addr_take && hwrite)
      begin
        wr_pend_q <= 1'b1;
        wr_idx_q  <= idx_of(haddr);
        hreadyout <= 1'b0;
      end
      else if (addr_take)
        hrdata <= rd_word;
    end
  end

  assign rdy_clr = wr_pend_q && (wr_idx_q == clm_pkg::IDX_LOCK_SUP_CTRL)
                   && !hwdata[clm_pkg::BIT_FREQ_RDY];

  // Software-owned control fields
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q.pd_inhibit <= 1'b0;
      ctrl_q.recheck_n  <= clm_pkg::RECHK_RESET;
      ctrl_q.tol_scale  <= clm_pkg::SCALE_RESET;
      ctrl_q.ppm_delta  <= clm_pkg::PPM_RESET;
      ctrl_q.eye_limits <= clm_pkg::EYE_RESET;
    end
    else if (wr_pend_q)
    begin
      unique case (wr_idx_q)
        clm_pkg::IDX_LOCK_SUP_CTRL:
        begin
          ctrl_q.pd_inhibit <= hwdata[clm_pkg::BIT_PD_INHIBIT];
          ctrl_q.recheck_n  <= {hwdata[clm_pkg::BIT_RECHK_HI],
                                hwdata[clm_pkg::BIT_RECHK_LO]};
        end
        clm_pkg::IDX_TOL_SCALE:
          ctrl_q.tol_scale <= {hwdata[clm_pkg::BIT_SCALE_HI], hwdata[clm_pkg::BIT_SCALE_LO]};
        clm_pkg::IDX_PPM_DELTA:  ctrl_q.ppm_delta  <= hwdata[7:0];
        clm_pkg::IDX_EYE_THRESH: ctrl_q.eye_limits <= hwdata[7:0];
        default:                 ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Frequency-error capture; a new capture wins over a software clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      freq_q <= '0;
    else if (freq_err_valid)
    begin
      freq_q.count <= freq_err_count;
      freq_q.ready <= 1'b1;
    end
    else if (rdy_clr)
      freq_q.ready <= 1'b0;
  end

  // Lock supervision with re-check counting
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q     <= clm_pkg::CLM_ACQUIRE;
      rechk_cnt_q <= 2'h0;
    end
    else if (lock_check)
    begin
      unique case (state_q)
        clm_pkg::CLM_ACQUIRE:
          if (lock_ok)
            state_q <= clm_pkg::CLM_LOCKED;
        clm_pkg::CLM_LOCKED: // Supervision never stops while locked
          if (!lock_ok)
          begin
            rechk_cnt_q <= 2'h0;
            state_q     <= (ctrl_q.recheck_n == 2'h0) ? clm_pkg::CLM_ACQUIRE
                                                      : clm_pkg::CLM_RECHECK;
          end
        clm_pkg::CLM_RECHECK:
          if (lock_ok)
          begin
            rechk_cnt_q <= 2'h0;
            state_q     <= clm_pkg::CLM_LOCKED;
          end
          else if (rechk_cnt_q + 2'h1 >= ctrl_q.recheck_n)
          begin
            rechk_cnt_q <= 2'h0;
            state_q     <= clm_pkg::CLM_ACQUIRE;
          end
          else
            rechk_cnt_q <= rechk_cnt_q + 2'h1;
        default: state_q <= clm_pkg::CLM_ACQUIRE;
      endcase
    end
  end

  // Lock indicator, held through re-checks
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cdr_locked <= 1'b0;
    else
      cdr_locked <= (state_q != clm_pkg::CLM_ACQUIRE);
  end

  // Idle timer and power-down after loss of input
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idle_cnt_q          <= '0;
      blocks_powered_down <= 1'b0;
    end
    else if (sig_detect || ctrl_q.pd_inhibit)
    begin
      idle_cnt_q          <= '0;
      blocks_powered_down <= 1'b0;
    end
    else if (idle_cnt_q == clm_pkg::PD_CNT_W'(PD_CYCLES - 1))
      blocks_powered_down <= 1'b1;
    else
      idle_cnt_q <= idle_cnt_q + 1'b1;
  end

  // Scaled frequency-delta tolerance
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      lock_tolerance <= '0;
    else
      lock_tolerance <= clm_pkg::TOL_W'({3'h0, ctrl_q.ppm_delta} << ctrl_q.tol_scale);
  end

  a_rdy_on_capture: assert property (@(posedge clk) disable iff (sys_rst)
    freq_err_valid |=> freq_q.ready && freq_q.count == $past(freq_err_count))
    else $error("ready flag or count not captured");
  a_pd_inhibit_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sig_detect || ctrl_q.pd_inhibit) |-> !blocks_powered_down)
    else $error("power-down despite input or inhibit");
  a_pd_delay_exact: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(blocks_powered_down) |-> idle_cnt_q == clm_pkg::PD_CNT_W'(PD_CYCLES - 1))
    else $error("power-down before the idle delay");
  a_zero_n_loss: assert property (@(posedge clk) disable iff (sys_rst)
    (lock_check && !lock_ok && state_q == clm_pkg::CLM_LOCKED && ctrl_q.recheck_n == 2'h0)
    |=> ##1 !cdr_locked)
    else $error("loss not declared with zero re-checks");
  a_three_rechecks: assert property (@(posedge clk) disable iff (sys_rst)
    (lock_check && !lock_ok && state_q == clm_pkg::CLM_LOCKED && ctrl_q.recheck_n == 2'h3)
    |=> ##1 cdr_locked)
    else $error("loss declared before re-checks");
  a_regain_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (lock_check && lock_ok && state_q == clm_pkg::CLM_RECHECK)
    |=> rechk_cnt_q == 2'h0 && state_q == clm_pkg::CLM_LOCKED ##1 cdr_locked)
    else $error("regain did not clear counter");
  a_locked_persist: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == clm_pkg::CLM_LOCKED && !lock_check) |=> state_q == clm_pkg::CLM_LOCKED)
    else $error("lock dropped without a check");
  a_unity_scale: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_q.tol_scale == 2'h0 |=> lock_tolerance == {3'h0, $past(ctrl_q.ppm_delta)})
    else $error("code 00 did not apply unity scale");
  a_okay_resp: assert property (@(posedge clk) disable iff (sys_rst)
    !hresp)
    else $error("non-OKAY response");

  c_loss: cover property (@(posedge clk) disable iff (sys_rst) $fell(cdr_locked));
  c_regain: cover property (@(posedge clk) disable iff (sys_rst)
    lock_check && lock_ok && state_q == clm_pkg::CLM_RECHECK);
  c_powerdown: cover property (@(posedge clk) disable iff (sys_rst) $rose(blocks_powered_down));
  c_rdy_clear: cover property (@(posedge clk) disable iff (sys_rst) $fell(freq_q.ready));

endmodule

// ### tb/clm_lock_monitor_tb.sv
// Self-checking testbench for the lock supervision register bank
`timescale 1ns/100ps
module clm_lock_monitor_tb;
  localparam int PD = 16;
  logic                      clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic                      sig_detect, lock_check, lock_ok, freq_err_valid;
  logic                      cdr_locked, blocks_powered_down;
  logic [1:0]                htrans;
  logic [31:0]               haddr, hwdata, hrdata, rd;
  logic [15:0]               freq_err_count;
  logic [clm_pkg::TOL_W-1:0] lock_tolerance;
  int                        n_errors = 0, comparisons = 0;
  // Device under test, short power-down count
  clm_lock_monitor #(.PD_CYCLES(PD)) clm_lock_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sig_detect(sig_detect),
    .lock_check(lock_check), .lock_ok(lock_ok), .freq_err_valid(freq_err_valid),
    .freq_err_count(freq_err_count), .cdr_locked(cdr_locked),
    .blocks_powered_down(blocks_powered_down), .lock_tolerance(lock_tolerance));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts and verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounded wait for hready high at an edge
  task automatic wait_rdy();
    for (int i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        return;
    end
    n_errors++;
    complete_run();
  endtask

  // One AHB single transfer, entered just after an edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask

  // One lock evaluation, then the declared lock state
  task automatic lchk(input logic ok, input logic exp);
    lock_check <= 1'b1;
    lock_ok <= ok;
    @(posedge clk);
    lock_check <= 1'b0;
    repeat (3) @(posedge clk);
    check("cdr_locked", {31'h0, cdr_locked}, {31'h0, exp});
  endtask

  // Main sequence
  initial
  begin
    {sys_rst, sig_detect} = 2'h3;
    {hsel, hwrite, htrans, lock_check, lock_ok, freq_err_valid} = 7'h00;
    {haddr, hwdata, freq_err_count} = 80'h0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rdchk("ctrl", clm_pkg::IDX_LOCK_SUP_CTRL, 32'h30);
    check("hresp", {31'h0, hresp}, 32'h0);
    rdchk("scale", clm_pkg::IDX_TOL_SCALE, 32'h0);
    rdchk("unmapped", 8'hff, 32'h0);
    bus(1'b1, clm_pkg::IDX_EYE_THRESH, 32'h5a);
    rdchk("eye", clm_pkg::IDX_EYE_THRESH, 32'h5a);
    $display("test reset done");
    // Capture a count, read it, clear ready
    freq_err_count <= 16'h5ac3;
    freq_err_valid <= 1'b1;
    @(posedge clk);
    freq_err_valid <= 1'b0;
    @(posedge clk);
    rdchk("ready", clm_pkg::IDX_LOCK_SUP_CTRL, 32'hb0);
    rdchk("count_hi", clm_pkg::IDX_FREQ_ERR_HI, 32'h5a);
    rdchk("count_lo", clm_pkg::IDX_FREQ_ERR_LO, 32'hc3);
    bus(1'b1, clm_pkg::IDX_LOCK_SUP_CTRL, 32'h30);
    rdchk("ready_clr", clm_pkg::IDX_LOCK_SUP_CTRL, 32'h30);
    $display("test capture done");
    // Every scale code on one tolerance
    bus(1'b1, clm_pkg::IDX_PPM_DELTA, 32'hb7);
    rdchk("ppm", clm_pkg::IDX_PPM_DELTA, 32'hb7);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, clm_pkg::IDX_TOL_SCALE, 32'(c) << 6);
      @(posedge clk);
      check("tolerance", 32'(lock_tolerance), 32'hb7 << c);
    end
    $display("test scale done");
    // Every re-check count: N failures kept, one more loses lock
    for (int n = 0; n < 4; n++)
    begin
      bus(1'b1, clm_pkg::IDX_LOCK_SUP_CTRL, 32'(n) << 4);
      lchk(1'b1, 1'b1);
      repeat (n) lchk(1'b0, 1'b1);
      lchk(1'b0, 1'b0);
    end
    // Regain during re-checks restarts the count
    bus(1'b1, clm_pkg::IDX_LOCK_SUP_CTRL, 32'h20);
    lchk(1'b1, 1'b1);
    repeat (2) lchk(1'b0, 1'b1);
    lchk(1'b1, 1'b1);
    repeat (2) lchk(1'b0, 1'b1);
    lchk(1'b0, 1'b0);
    $display("test recheck done");
    // Idle power-down after the delay, released on signal
    sig_detect <= 1'b0;
    repeat (PD) @(posedge clk);
    check("pd_early", {31'h0, blocks_powered_down}, 32'h0);
    @(posedge clk);
    check("pd", {31'h0, blocks_powered_down}, 32'h1);
    sig_detect <= 1'b1;
    repeat (3) @(posedge clk);
    check("pd_release", {31'h0, blocks_powered_down}, 32'h0);
    bus(1'b1, clm_pkg::IDX_LOCK_SUP_CTRL, 32'h70);
    sig_detect <= 1'b0;
    repeat (PD + 8) @(posedge clk);
    check("pd_inhibit", {31'h0, blocks_powered_down}, 32'h0);
    $display("test power_down done");
    complete_run();
  end
endmodule
